// ### core/ftc_fan_tach_counter.v
/*
 * Two-fan tachometer counter with an AXI4-Lite register slave.
 * Assumes tachometer inputs already synchronous to clock; one write and
 * one read outstanding at most, as AXI4-Lite masters behave.
 */
// The AXI4-Lite slave port was decided locally.
//
// Contract
// - Fan two count clock from source bit, multiplier bit and its clock select.
// - Config bit 2 is fan one multiplier; zero leaves clock unmultiplied.
// - Fan one multiplier set doubles clock chosen by config bit 0 and select.
// - Config bit 3 doubles fan two clock chosen by bit 1 and select.
// - Fan one divisor from config bits 5:4: 1, 2, 4 or 8.
// - Fan two divisor from config bits 7:6, same encoding.
// - Both divisor fields select divide by two after reset.
// - Fan one result held as an 8-bit count.
// - Count divided count clock ticks over each tachometer period.
// - Latch final count of previous period; running count never visible.
`timescale 1ns/1ps
`default_nettype none
`include "ftc_defines.vh"

module ftc_fan_tach_counter (
	// Clock and reset
	input  wire        clock,
	input  wire        rst_n,
	// Fan tachometer inputs
	input  wire        fanOneTach,
	input  wire        fanTwoTach,
	// AXI4-Lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ======================================================================
	// Functions

	// Returns the register index, or 8'hFF when the address is misaligned or has bits 11:10 set
	function [7:0] regIndex;
		input [11:0] addr;
		begin
			if (addr[11:10] != 2'h0 || addr[1:0] != 2'h0) begin
				regIndex = 8'hFF;
			end else begin
				regIndex = addr[9:2];
			end
		end
	endfunction

	function isMapped;
		input [7:0] idx;
		begin
			isMapped = (idx == `FTC_IDX_FIRST_FAN_CHANNEL_CLKSEL) ||
			           (idx == `FTC_IDX_SECOND_FAN_CHANNEL_CLKSEL) ||
			           (idx == `FTC_IDX_FIRST_FAN_CHANNEL_COUNT)  ||
			           (idx == `FTC_IDX_SECOND_FAN_CHANNEL_COUNT)  ||
			           (idx == `FTC_IDX_DIV_CONFIG);
		end
	endfunction

	// Unmapped or misaligned access answers with an error
	function [1:0] respCode;
		input [7:0] idx;
		begin
			if (isMapped(idx)) begin
				respCode = `FTC_RESP_OKAY;
			end else begin
				respCode = `FTC_RESP_SLVERR;
			end
		end
	endfunction

	// Registers are one byte wide; upper lanes read zero
	function [31:0] byteWord;
		input [7:0] value;
		begin
			byteWord = {24'h000000, value};
		end
	endfunction

	// Count clock period in system cycles for one fan
	function [15:0] tickPeriod;
		input       src;
		input       sel;
		input       mult;
		input [1:0] div;
		reg   [15:0] base;
		reg   [15:0] half;
		begin
			case ({src, sel})
				2'h0:    base = `FTC_BASE_PER_00;
				2'h1:    base = `FTC_BASE_PER_01;
				2'h2:    base = `FTC_BASE_PER_10;
				default: base = `FTC_BASE_PER_11;
			endcase
			// Doubling the count clock halves its period
			half = mult ? {1'b0, base[15:1]} : base;
			// Larger divisor means a slower count clock
			tickPeriod = half << div;
		end
	endfunction

	// ======================================================================
	// Registers

	reg [7:0]  cfg_ff;
	reg [7:0]  clkSelOne_ff;
	reg [7:0]  clkSelTwo_ff;
	reg [7:0]  result_ff [0:1];
	reg [7:0]  count_ff [0:1];
	reg [15:0] preCnt_ff [0:1];
	reg [1:0]  tachPrev_ff;

	reg        awready_ff;
	reg        wready_ff;
	reg        awGot_ff;
	reg        wGot_ff;
	reg [11:0] awAddr_ff;
	reg [31:0] wData_ff;
	reg [3:0]  wStrb_ff;
	reg        bvalid_ff;
	reg [1:0]  bresp_ff;
	reg        arready_ff;
	reg        rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0]  rresp_ff;

	wire [1:0] tachNow;
	wire [15:0] period [0:1];

	assign tachNow = {fanTwoTach, fanOneTach};

	assign period[0] = tickPeriod(cfg_ff[`FTC_CFG_SRC1_BIT],
		clkSelOne_ff[`FTC_CLKSEL_BIT], cfg_ff[`FTC_CFG_MUL1_BIT],
		cfg_ff[`FTC_CFG_DIV1_LSB+1:`FTC_CFG_DIV1_LSB]);
	assign period[1] = tickPeriod(cfg_ff[`FTC_CFG_SRC2_BIT],
		clkSelTwo_ff[`FTC_CLKSEL_BIT], cfg_ff[`FTC_CFG_MUL2_BIT],
		cfg_ff[`FTC_CFG_DIV2_LSB+1:`FTC_CFG_DIV2_LSB]);

	// ======================================================================
	// Edge and tick strobes

	wire [1:0] tachRise;
	wire [1:0] tickDue;
	wire [1:0] countFull;

	assign tachRise     = tachNow & ~tachPrev_ff;
	// A tick is due when the prescaler reaches one less than its period
	assign tickDue[0]   = (preCnt_ff[0] >= period[0] - 16'h0001);
	assign tickDue[1]   = (preCnt_ff[1] >= period[1] - 16'h0001);
	assign countFull[0] = (count_ff[0] == 8'hFF);
	assign countFull[1] = (count_ff[1] == 8'hFF);

	// ======================================================================
	// Tachometer measurement

	integer i;

	// A config change applies at once, so the period in flight mixes both
	always @(posedge clock) begin
		if (!rst_n) begin
			// Take the pin level so a fan already high gives no false edge
			tachPrev_ff <= tachNow;
			for (i = 0; i < 2; i = i + 1) begin
				preCnt_ff[i] <= 16'h0000;
				count_ff[i]  <= 8'h00;
				result_ff[i] <= `FTC_COUNT_RESET;
			end
		end else begin
			tachPrev_ff <= tachNow;
			for (i = 0; i < 2; i = i + 1) begin
				if (tachRise[i]) begin
					// Rising edge closes one full period
					result_ff[i] <= count_ff[i];
					count_ff[i]  <= 8'h00;
					preCnt_ff[i] <= 16'h0000;
				end else if (tickDue[i]) begin
					preCnt_ff[i] <= 16'h0000;
					// Slow fan reads as the largest count; a stalled fan keeps its last result
					if (!countFull[i]) begin
						count_ff[i] <= count_ff[i] + 8'h01;
					end
				end else begin
					preCnt_ff[i] <= preCnt_ff[i] + 16'h0001;
				end
			end
		end
	end

	// ======================================================================
	// AXI4-Lite write path

	wire awTake;
	wire wTake;
	wire doWrite;
	wire [7:0] wIdx;

	assign awTake  = s_axi_awvalid && awready_ff;
	assign wTake   = s_axi_wvalid && wready_ff;
	assign doWrite = awGot_ff && wGot_ff && !bvalid_ff;
	assign wIdx    = regIndex(awAddr_ff);

	always @(posedge clock) begin
		if (!rst_n) begin
			awready_ff   <= 1'b1;
			wready_ff    <= 1'b1;
			awGot_ff     <= 1'b0;
			wGot_ff      <= 1'b0;
			awAddr_ff    <= 12'h000;
			wData_ff     <= 32'h00000000;
			wStrb_ff     <= 4'h0;
			bvalid_ff    <= 1'b0;
			bresp_ff     <= `FTC_RESP_OKAY;
			cfg_ff       <= `FTC_CFG_RESET;
			clkSelOne_ff <= `FTC_CLKSEL_RESET;
			clkSelTwo_ff <= `FTC_CLKSEL_RESET;
		end else begin
			if (awTake) begin
				awAddr_ff  <= s_axi_awaddr;
				awGot_ff   <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (wTake) begin
				wData_ff  <= s_axi_wdata;
				wStrb_ff  <= s_axi_wstrb;
				wGot_ff   <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (doWrite) begin
				awGot_ff  <= 1'b0;
				wGot_ff   <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= respCode(wIdx);
				// Only lane 0 carries data; count registers ignore writes
				if (wStrb_ff[0]) begin
					case (wIdx)
						`FTC_IDX_DIV_CONFIG: begin
							cfg_ff <= wData_ff[7:0];
						end
						`FTC_IDX_FIRST_FAN_CHANNEL_CLKSEL: begin
							clkSelOne_ff <= wData_ff[7:0];
						end
						`FTC_IDX_SECOND_FAN_CHANNEL_CLKSEL: begin
							clkSelTwo_ff <= wData_ff[7:0];
						end
						default: begin
						end
					endcase
				end
			end
			// Readies reopen only once the answer is taken
			if (bvalid_ff && s_axi_bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// ======================================================================
	// AXI4-Lite read path

	wire arTake;
	wire [7:0] rIdx;

	assign arTake = s_axi_arvalid && arready_ff;
	assign rIdx   = regIndex(s_axi_araddr);

	always @(posedge clock) begin
		if (!rst_n) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= `FTC_RESP_OKAY;
		end else begin
			// Answer stands until rready; arready stays low meanwhile
			if (arTake) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rresp_ff   <= respCode(rIdx);
				case (rIdx)
					`FTC_IDX_DIV_CONFIG: begin
						rdata_ff <= byteWord(cfg_ff);
					end
					`FTC_IDX_FIRST_FAN_CHANNEL_CLKSEL: begin
						rdata_ff <= byteWord(clkSelOne_ff);
					end
					`FTC_IDX_SECOND_FAN_CHANNEL_CLKSEL: begin
						rdata_ff <= byteWord(clkSelTwo_ff);
					end
					`FTC_IDX_FIRST_FAN_CHANNEL_COUNT: begin
						rdata_ff <= byteWord(result_ff[0]);
					end
					`FTC_IDX_SECOND_FAN_CHANNEL_COUNT: begin
						rdata_ff <= byteWord(result_ff[1]);
					end
					default: begin
						rdata_ff <= 32'h00000000;
					end
				endcase
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Outputs

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

endmodule

`default_nettype wire

// ### inc/ftc_defines.vh
/*
 * Offsets, field positions, reset values and timing counts for the two-fan
 * tachometer counter.
 * Assumes it is included by bare name from a design file.
 */
`ifndef FTC_DEFINES_VH
`define FTC_DEFINES_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define FTC_IDX_FIRST_FAN_CHANNEL_CLKSEL   8'h56
`define FTC_IDX_SECOND_FAN_CHANNEL_CLKSEL   8'h57
`define FTC_IDX_FIRST_FAN_CHANNEL_COUNT    8'h59
`define FTC_IDX_SECOND_FAN_CHANNEL_COUNT    8'h5A
`define FTC_IDX_DIV_CONFIG    8'h5B

// ==========================================================================
// Configuration register fields
`define FTC_CFG_SRC1_BIT      0
`define FTC_CFG_SRC2_BIT      1
`define FTC_CFG_MUL1_BIT      2
`define FTC_CFG_MUL2_BIT      3
`define FTC_CFG_DIV1_LSB      4
`define FTC_CFG_DIV2_LSB      6
`define FTC_CLKSEL_BIT        7

// ==========================================================================
// Reset values
`define FTC_CFG_RESET         8'h50
`define FTC_CLKSEL_RESET      8'h00
`define FTC_COUNT_RESET       8'h00

// ==========================================================================
// Count clock base periods in system clock cycles, by {source, select}
`define FTC_BASE_PER_00       16'h0640
`define FTC_BASE_PER_01       16'h0320
`define FTC_BASE_PER_10       16'h0190
`define FTC_BASE_PER_11       16'h00C8

// ==========================================================================
// Bus answers
`define FTC_RESP_OKAY         2'h0
`define FTC_RESP_SLVERR       2'h2

`endif

// ### dv/ftc_tach_gen.sv
/* Fan tachometer model: square wave of a settable period in cycles.
   Assumes the period is at least four cycles. */
`timescale 1ns/1ps
`default_nettype none
module ftc_tach_gen (
	// Clock and period
	input	wire logic		clock,
	input	wire logic [31:0]	period,
	// Tachometer line and completed high phases
	output	var logic		tach,
	output	var int			pulses
);
	int	cnt = 0;
	initial begin
		tach = 1'b0;
		pulses = 0;
	end
	// Counted on the fall so the counter has latched by then
	always @(posedge clock) begin
		cnt <= (cnt >= period - 1) ? 0 : cnt + 1;
		tach <= (cnt < period / 2);
		pulses <= pulses + int'(cnt == period / 2);
	end
endmodule
`default_nettype wire

// ### dv/ftc_tach_sva.sv
/* Bus timing checks for the tachometer counter.
   Assumes it is bound to the top module by port names. */
`timescale 1ns/1ps
`default_nettype none
module ftc_tach_sva (
	// Clock and reset
	input	wire logic		clock,
	input	wire logic		rst_n,
	// Write channels
	input	wire logic		s_axi_awvalid,
	input	wire logic		s_axi_awready,
	input	wire logic		s_axi_wvalid,
	input	wire logic		s_axi_wready,
	input	wire logic [1:0]	s_axi_bresp,
	input	wire logic		s_axi_bvalid,
	input	wire logic		s_axi_bready,
	// Read channels
	input	wire logic [11:0]	s_axi_araddr,
	input	wire logic		s_axi_arvalid,
	input	wire logic		s_axi_arready,
	input	wire logic [31:0]	s_axi_rdata,
	input	wire logic [1:0]	s_axi_rresp,
	input	wire logic		s_axi_rvalid,
	input	wire logic		s_axi_rready
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	upper_zero_a: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	rd_end_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready) else $error("read not ended");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write answer late");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer moved");
	bad_addr_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == 2'h2
		&& s_axi_rdata == 32'h0) else $error("misaligned read accepted");
	reset_idle_a: assert property ($rose(rst_n)
		|-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready)
		else $error("bus busy after reset");
endmodule
`default_nettype wire

// ### dv/fan_tach_divisor_counter_test.sv
/* Bench for the tachometer counter: bus master tasks, tachometer
   models and a count reference. Assumes checker and model compiled. */
`timescale 1ns/1ps
`default_nettype none
module fan_tach_divisor_counter_test;
	logic		clock = 1'b0;
	logic		rst_n = 1'b0;
	logic		fanOneTach, fanTwoTach;
	logic [11:0]	s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0]	s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]	s_axi_wstrb = 4'hF;
	logic [1:0]	s_axi_bresp, s_axi_rresp, resp;
	logic		s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic		s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
	logic		s_axi_rready = 1'b0;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic		s_axi_arready, s_axi_rvalid;
	logic [4:0]	cases [8] = '{5'h1C, 5'h1D, 5'h1E, 5'h1F,
				  5'h18, 5'h0C, 5'h14, 5'h04};
	logic [4:0]	c;
	logic [7:0]	cfgv;
	logic [31:0]	perOne = 32'h3E8, perTwo = 32'd26000;
	int		n_errors = 0, checks = 0, seed = 32'hA194E0A8;
	int		pulsesOne, pulsesTwo, k, p, i, e2, per1, exp1;
	always #10 clock = ~clock;
	ftc_fan_tach_counter ftc_fan_tach_counter_i (.clock, .rst_n, .fanOneTach,
		.fanTwoTach, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	ftc_tach_gen genOne (.clock, .period(perOne), .tach(fanOneTach),
		.pulses(pulsesOne));
	ftc_tach_gen genTwo (.clock, .period(perTwo), .tach(fanTwoTach),
		.pulses(pulsesTwo));
	// ==================================================================
	// Bus tasks; answer ready raised late at random to stretch answers
	task automatic axw(input logic [11:0] a, input logic [7:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($random(seed)), d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'($random(seed));
		for (n = 0; n < 99; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			// Once raised, ready stays up until the answer is taken
			if (!s_axi_bready) s_axi_bready <= 1'($random(seed));
		end
		resp = s_axi_bresp;
		if (n == 99) report_and_stop(1);
	endtask
	task automatic axr(input logic [11:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($random(seed));
		for (n = 0; n < 99; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (!s_axi_rready) s_axi_rready <= 1'($random(seed));
		end
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		if (n == 99) report_and_stop(1);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, got);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	task automatic rdchk(input logic [11:0] a, input int exp, input int er);
		axr(a);
		chk("rdata", 32'(exp), rd);
		chk("rresp", 32'(er), {30'h0, resp});
	endtask
	task automatic wait_pulses(input logic two, input int target);
		int n;
		for (n = 0; n < 99999 && (two ? pulsesTwo : pulsesOne) < target; n++)
			@(posedge clock);
		if (n == 99999) report_and_stop(1);
	endtask
	// Reference: expected count from source, select, multiplier, divisor and tach period
	function automatic int expCount(input int ss, mul, div, per);
		int q;
		q = ((1600 >> ss) >> mul) << div;
		return (per / q > 255) ? 255 : per / q;
	endfunction
	task automatic report_and_stop(input int extra);
		n_errors += extra;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==================================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		rdchk(12'h16C, 32'h50, 0);
		rdchk(12'h164, 32'h0, 0);
		rdchk(12'h165, 32'h0, 2);
		rdchk(12'h170, 32'h0, 2);
		axw(12'h164, 8'h5A);
		chk("bresp", 32'h0, {30'h0, resp});
		rdchk(12'h164, 32'h0, 0);
		axw(12'h170, 8'h11);
		chk("bresp", 32'h2, {30'h0, resp});
		s_axi_wstrb <= 4'hE;
		axw(12'h16C, 8'h00);
		s_axi_wstrb <= 4'hF;
		rdchk(12'h16C, 32'h50, 0);
		axw(12'h15C, 8'h80);
		chk("bresp", 32'h0, {30'h0, resp});
		axw(12'h16C, 8'h0A);
		e2 = pulsesTwo;
		for (i = 0; i < 8; i++) begin
			c = cases[i];
			p = ((1600 >> c[4:3]) >> c[2]) << c[1:0];
			k = 2 + int'({$random(seed)} % 4);
			// Half a tick past whole ticks keeps the truncation clear
			per1 = k * p + p / 2;
			perOne <= 32'(per1);
			cfgv = {2'h0, c[1:0], 1'b1, c[2], 1'b1, c[4]};
			axw(12'h158, {c[3], 7'h00});
			axw(12'h16C, cfgv);
			rdchk(12'h16C, cfgv, 0);
			wait_pulses(1'b0, pulsesOne + 3);
			exp1 = expCount(c[4:3], c[2], c[1:0], per1);
			rdchk(12'h164, exp1, 0);
		end
		wait_pulses(1'b1, e2 + 3);
		rdchk(12'h168, expCount(3, 1, 0, 26000), 0);
		report_and_stop(0);
	end
endmodule
bind ftc_fan_tach_counter ftc_tach_sva ftc_tach_sva_i (.clock, .rst_n,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready);
`default_nettype wire
